// ---- include/dsmcc_params.svh ----
// Constants of the dual switch mode and channel control block
// Summary of operation
// RULE1: Four modes only: Sleep, Normal, Fail-safe, Fault, picked from wake, fail-safe, fault.
// RULE2: Wake-up clears all serial registers, enters Normal; functions ready 50 us later. The code keeps the sticky bits of the fault registers over a wake-up.
// RULE3: Controller wakes via wake reset input or a direct input, after supplies are valid.
// RULE4: Rising edge on wake reset input or either direct input enters Normal mode.
// RULE5: Normal mode and its flag only while wake 1, fail-safe 0, fault 0.
// RULE6: In Normal each channel runs by direct input, internal clock or external clock.
// RULE7: Internal clock select 1 drives the channel from the programmable internal clock.
// RULE8: External clock mode takes PWM period from external clock; other settings programmable.
// RULE9: PWM runs at up to 1.0 kHz, internal or external clock, chosen by registers.
// RULE10: Target on state ORs direct, on-and-duty with PWM, and on without PWM terms.
// RULE11: Duty term comes from bits 7..0 of the channel's pulse width register.
// RULE12: Each channel has its own duty, delay, slew, PWM enable, clock, prescaler, direct disable.
// RULE13: Status register shows each channel's on and fault state; fault register pins type.
// RULE14: Controller toggles the watchdog bit within 310 ms unless watchdog disabled.
// RULE15: Input activity flag drops after more than 250 ms without direct input activity.
// RULE16: Both activity flags low and wake reset input low gives Sleep mode.
// RULE17: With wake reset input low or in Fail-safe, only direct inputs steer channels.
// RULE18: Controller holds wake reset input high when direct inputs run below 4.0 Hz.
// RULE19: Watchdog disable, bit 4 of global config, blocks Fail-safe on watchdog timeout.
// RULE20: Wake 1 and fault 1 always gives Fault mode with channels off.
// RULE21: Inactivity timer restarts on each high input level, runs on the core clock.
`ifndef DSMCC_PARAMS_SVH
`define DSMCC_PARAMS_SVH

// ****************************************
// Register indices
// ****************************************
`define DSMCC_ADDR_GCR 4'h0
`define DSMCC_ADDR_STATUS 4'h1
`define DSMCC_ADDR_PWM0 4'h2
`define DSMCC_ADDR_PWM1 4'h3
`define DSMCC_ADDR_CONF0 4'h4
`define DSMCC_ADDR_CONF1 4'h5
`define DSMCC_ADDR_FAULT0 4'h6
`define DSMCC_ADDR_FAULT1 4'h7

// ****************************************
// Field positions
// ****************************************
`define DSMCC_WATCHDOG_TOGGLE_BIT_BIT 15
`define DSMCC_GCR_WATCHDOG_DISABLE_BIT 4
`define DSMCC_GCR_VDD_EN_BIT 5
`define DSMCC_DUTY_MSB 7
`define DSMCC_CONF_MSB 11
`define DSMCC_DELAY_SHIFT 5

// ****************************************
// Reset values
// ****************************************
`define DSMCC_RST_DUTY 8'h00
`define DSMCC_RST_CONF 12'h000

// ****************************************
// Timing
// ****************************************
`define DSMCC_CLK_PERIOD_NS 8
`define DSMCC_T_READY_US 50
`define DSMCC_T_IN_MS 250
`define DSMCC_T_WDTO_MS 310
`define DSMCC_PWM_MAX_HZ 1000
`define DSMCC_PWM_STEPS 256
`define DSMCC_T_READY_CYC \
   ((`DSMCC_T_READY_US * 1000 + `DSMCC_CLK_PERIOD_NS - 1) / `DSMCC_CLK_PERIOD_NS)
`define DSMCC_T_IN_CYC \
   ((`DSMCC_T_IN_MS * 1000000 + `DSMCC_CLK_PERIOD_NS - 1) / `DSMCC_CLK_PERIOD_NS)
`define DSMCC_T_WDTO_CYC \
   ((`DSMCC_T_WDTO_MS * 1000000 + `DSMCC_CLK_PERIOD_NS - 1) / `DSMCC_CLK_PERIOD_NS)
`define DSMCC_PWM_STEP_CYC \
   ((1000000000 / (`DSMCC_PWM_MAX_HZ * `DSMCC_PWM_STEPS) \
   + `DSMCC_CLK_PERIOD_NS - 1) / `DSMCC_CLK_PERIOD_NS)

`endif

// ---- include/dsmcc_pkg.sv ----
// Types of the dual switch mode and channel control block
package dsmcc_pkg;

   typedef enum logic [3:0] {
      DSMCC_SLEEP = 4'h1,
      DSMCC_NORMAL = 4'h2,
      DSMCC_FAILSAFE = 4'h4,
      DSMCC_FAULT = 4'h8
   } dsmcc_mode_t;

   typedef struct packed {
      logic [2:0] delay;
      logic [1:0] slew;
      logic [2:0] prescaler;
      logic dir_dis;
      logic clk_int;
      logic pwm_en;
      logic on;
   } dsmcc_conf_t;

   typedef struct packed {
      logic [8:0] base_cnt;
      logic [2:0] pre_cnt;
      logic [7:0] step;
      logic pwm;
   } dsmcc_chan_state_t;

   typedef struct packed {
      logic [6:0] sync1;
      logic [6:0] sync2;
      logic [6:0] sync3;
      dsmcc_mode_t mode;
      logic ready;
      logic [31:0] ready_cnt;
      logic [1:0] in_on;
      logic [1:0][31:0] in_cnt;
      logic [31:0] wd_cnt;
      logic wd_last;
      logic wd_to;
      logic watchdog_disable;
      logic vdd_fail_en;
      logic [1:0][7:0] duty;
      dsmcc_conf_t [1:0] conf;
      logic [1:0] chan_fault;
      logic [15:0] rdata;
      logic [1:0] hson;
      logic nm;
      logic fs_n;
      logic [3:0] slew;
   } dsmcc_state_t;

endpackage

// ---- include/dsmcc_chan_if.sv ----
// Carrier between the mode controller and one PWM channel
`timescale 1ns/1ps
interface dsmcc_chan_if;
   import dsmcc_pkg::*;
   logic [7:0] duty;
   dsmcc_conf_t conf;
   logic ext_rise;
   logic pwm;
   modport ctrl (output duty, output conf, output ext_rise, input pwm);
   modport chan (input duty, input conf, input ext_rise, output pwm);
endinterface

// ---- logic/dsmcc_chan.sv ----
// PWM duty generator of one channel
`timescale 1ns/1ps
`include "dsmcc_params.svh"
module dsmcc_chan
   import dsmcc_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   dsmcc_chan_if.chan c
);

   localparam logic [8:0] STEP_CYC = 9'(`DSMCC_PWM_STEP_CYC);

   dsmcc_chan_state_t s;
   dsmcc_chan_state_t next_s;
   logic [7:0] phase;

   always_comb begin
      next_s = s;
      phase = 8'h00;
      // External edge restarts the period; step sticks at the top until
      // the next edge so a slow external clock gives no extra pulses
      if (c.ext_rise && !c.conf.clk_int) begin // RULE8
         next_s.step = 8'h00;
         next_s.base_cnt = 9'h000;
         next_s.pre_cnt = 3'h0;
      end else if (s.base_cnt == STEP_CYC - 9'h001) begin // RULE9
         next_s.base_cnt = 9'h000;
         if (s.pre_cnt == c.conf.prescaler) begin // RULE7
            next_s.pre_cnt = 3'h0;
            if (c.conf.clk_int || s.step != 8'hFF) begin
               next_s.step = s.step + 8'h01;
            end
         end else begin
            next_s.pre_cnt = s.pre_cnt + 3'h1;
         end
      end else begin
         next_s.base_cnt = s.base_cnt + 9'h001;
      end
      // Turn-on delay shifts the on window within the period
      phase = s.step - {c.conf.delay, 5'h00};
      next_s.pwm = phase < c.duty; // RULE11
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign c.pwm = s.pwm;

endmodule

// ---- logic/dsmcc_top.sv ----
// Mode control, wake, watchdog and channel target logic of the switch
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "dsmcc_params.svh"
module dsmcc_top
   import dsmcc_pkg::*;
#(
   parameter int unsigned T_READY_CYC = `DSMCC_T_READY_CYC,
   parameter int unsigned T_IN_CYC = `DSMCC_T_IN_CYC,
   parameter int unsigned T_WDTO_CYC = `DSMCC_T_WDTO_CYC
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic wake_reset_input,
   input wire logic [1:0] direct_in,
   input wire logic ext_clock,
   input wire logic [1:0] fault_in,
   input wire logic vdd_fail,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   output logic [1:0] hson,
   output logic normal_mode_flag,
   output logic fail_safe_n,
   output logic [3:0] slew_code
);

   // ****************************************
   // State
   // ****************************************
   localparam logic [31:0] READY_LAST = 32'(T_READY_CYC - 1);
   localparam logic [31:0] IN_LAST = 32'(T_IN_CYC - 1);
   localparam logic [31:0] WDTO_LAST = 32'(T_WDTO_CYC - 1);

   dsmcc_state_t s;
   dsmcc_state_t next_s;
   logic [1:0] pwm;

   logic rst_lvl;
   logic rst_rise;
   logic [1:0] in_lvl;
   logic ext_rise;
   logic [1:0] flt;
   logic vdd_bad;
   logic wake;
   logic wake_evt;
   logic failsafe;
   logic fault_any;
   logic reg_ok;
   logic clr_regs;
   logic full;
   logic [1:0] rd_clr;

   // ****************************************
   // Channel generators
   // ****************************************
   for (genvar g = 0; g < 2; g++) begin : g_chan
      dsmcc_chan_if u_if ();
      assign u_if.duty = s.duty[g];
      assign u_if.conf = s.conf[g];
      assign u_if.ext_rise = ext_rise;
      assign pwm[g] = u_if.pwm;
      dsmcc_chan u_chan (
         .clk (clk),
         .rstn (rstn),
         .c (u_if)
      );
   end

   // Only the second and third sync stages are looked at
   assign rst_lvl = s.sync2[0];
   assign rst_rise = s.sync2[0] & ~s.sync3[0];
   assign in_lvl = s.sync2[2:1];
   assign ext_rise = s.sync2[3] & ~s.sync3[3];
   assign flt = s.sync2[5:4];
   assign vdd_bad = s.sync2[6];

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_s = s;
      wake = 1'b0;
      wake_evt = 1'b0;
      failsafe = 1'b0;
      fault_any = 1'b0;
      reg_ok = 1'b0;
      clr_regs = 1'b0;
      full = 1'b0;
      rd_clr = 2'b00;

      next_s.sync1 = {vdd_fail, fault_in, ext_clock, direct_in,
                      wake_reset_input};
      next_s.sync2 = s.sync1;
      next_s.sync3 = s.sync2;

      // Input activity: a high level keeps the flag, silence drops it
      for (int i = 0; i < 2; i++) begin
         if (in_lvl[i]) begin // RULE21
            next_s.in_on[i] = 1'b1;
            next_s.in_cnt[i] = 32'h0000_0000;
         end else if (s.in_on[i]) begin
            if (s.in_cnt[i] == IN_LAST) begin // RULE15
               next_s.in_on[i] = 1'b0;
               next_s.in_cnt[i] = 32'h0000_0000;
            end else begin
               next_s.in_cnt[i] = s.in_cnt[i] + 32'h0000_0001;
            end
         end
      end

      // Wake, fail-safe and fault conditions
      wake = rst_lvl | s.in_on[0] | s.in_on[1];
      wake_evt = (s.mode == DSMCC_SLEEP) & wake; // RULE4
      failsafe = (s.wd_to & ~s.watchdog_disable) // RULE19
               | (vdd_bad & s.vdd_fail_en);
      fault_any = |flt;

      if (!wake) begin // RULE16
         next_s.mode = DSMCC_SLEEP; // RULE1
      end else if (fault_any) begin // RULE20
         next_s.mode = DSMCC_FAULT;
      end else if (failsafe) begin
         next_s.mode = DSMCC_FAILSAFE;
      end else begin
         next_s.mode = DSMCC_NORMAL; // RULE5
      end
      next_s.nm = (next_s.mode == DSMCC_NORMAL); // RULE5
      next_s.fs_n = ~(wake & failsafe);

      // Start-up delay after a wake-up event
      if (wake_evt) begin // RULE2
         next_s.ready = 1'b0;
         next_s.ready_cnt = 32'h0000_0000;
      end else if (!wake) begin
         next_s.ready = 1'b0;
         next_s.ready_cnt = 32'h0000_0000;
      end else if (!s.ready) begin
         if (s.ready_cnt == READY_LAST) begin
            next_s.ready = 1'b1;
         end else begin
            next_s.ready_cnt = s.ready_cnt + 32'h0000_0001;
         end
      end

      // Serial watchdog: a written word counts only if bit 15 toggles (or is set after a timeout), whatever its address
      if (!rst_lvl || rst_rise) begin
         next_s.wd_cnt = 32'h0000_0000;
         next_s.wd_to = 1'b0;
         next_s.wd_last = 1'b0;
      end else if (wr && s.wd_to) begin
         if (wdata[`DSMCC_WATCHDOG_TOGGLE_BIT_BIT]) begin
            next_s.wd_to = 1'b0;
            next_s.wd_cnt = 32'h0000_0000;
            next_s.wd_last = 1'b1;
         end
      end else if (wr && (wdata[`DSMCC_WATCHDOG_TOGGLE_BIT_BIT] != s.wd_last)) begin
         next_s.wd_cnt = 32'h0000_0000;
         next_s.wd_last = wdata[`DSMCC_WATCHDOG_TOGGLE_BIT_BIT];
      end else if (!s.wd_to) begin
         if (s.wd_cnt == WDTO_LAST) begin
            next_s.wd_to = 1'b1;
         end else begin
            next_s.wd_cnt = s.wd_cnt + 32'h0000_0001;
         end
      end

      // Registers are writable only with the wake reset input high
      // and outside fail-safe; otherwise they are held at reset
      reg_ok = rst_lvl & ~failsafe & ~wake_evt;
      clr_regs = ~rst_lvl | failsafe | wake_evt; // RULE2

      if (clr_regs) begin
         next_s.watchdog_disable = 1'b0;
         next_s.vdd_fail_en = 1'b0;
         for (int i = 0; i < 2; i++) begin
            next_s.duty[i] = `DSMCC_RST_DUTY;
            next_s.conf[i] = `DSMCC_RST_CONF;
         end
      end else if (wr && reg_ok) begin
         unique case (addr)
            `DSMCC_ADDR_GCR: begin
               next_s.watchdog_disable = wdata[`DSMCC_GCR_WATCHDOG_DISABLE_BIT]; // RULE19
               next_s.vdd_fail_en = wdata[`DSMCC_GCR_VDD_EN_BIT];
            end
            `DSMCC_ADDR_PWM0: begin
               next_s.duty[0] = wdata[`DSMCC_DUTY_MSB:0]; // RULE11
            end
            `DSMCC_ADDR_PWM1: begin
               next_s.duty[1] = wdata[`DSMCC_DUTY_MSB:0]; // RULE11
            end
            `DSMCC_ADDR_CONF0: begin
               next_s.conf[0] = dsmcc_conf_t'(wdata[`DSMCC_CONF_MSB:0]); // RULE12
            end
            `DSMCC_ADDR_CONF1: begin
               next_s.conf[1] = dsmcc_conf_t'(wdata[`DSMCC_CONF_MSB:0]); // RULE12
            end
            default: begin
            end
         endcase
      end

      // Read port: data stand one cycle only, unmapped reads give zero
      next_s.rdata = 16'h0000;
      if (rd) begin
         unique case (addr)
            `DSMCC_ADDR_GCR: begin
               next_s.rdata = 16'h0000;
               next_s.rdata[`DSMCC_GCR_WATCHDOG_DISABLE_BIT] = s.watchdog_disable;
               next_s.rdata[`DSMCC_GCR_VDD_EN_BIT] = s.vdd_fail_en;
            end
            `DSMCC_ADDR_STATUS: begin
               next_s.rdata = {9'h000, s.ready, ~s.fs_n, s.nm,
                               flt, s.hson}; // RULE13
            end
            `DSMCC_ADDR_PWM0: begin
               next_s.rdata = {8'h00, s.duty[0]};
            end
            `DSMCC_ADDR_PWM1: begin
               next_s.rdata = {8'h00, s.duty[1]};
            end
            `DSMCC_ADDR_CONF0: begin
               next_s.rdata = {4'h0, s.conf[0]};
            end
            `DSMCC_ADDR_CONF1: begin
               next_s.rdata = {4'h0, s.conf[1]};
            end
            `DSMCC_ADDR_FAULT0: begin
               next_s.rdata = {15'h0000, s.chan_fault[0]};
               rd_clr[0] = 1'b1;
            end
            `DSMCC_ADDR_FAULT1: begin
               next_s.rdata = {15'h0000, s.chan_fault[1]};
               rd_clr[1] = 1'b1;
            end
            default: begin
               next_s.rdata = 16'h0000;
            end
         endcase
      end

      // Sticky fault bits: a fault in the clearing cycle is kept
      for (int i = 0; i < 2; i++) begin
         next_s.chan_fault[i] = (s.chan_fault[i] & ~rd_clr[i])
                              | flt[i]; // RULE13
      end

      // Target on state per channel
      for (int i = 0; i < 2; i++) begin
         full = (in_lvl[i] & ~s.conf[i].dir_dis) // RULE10
              | (s.conf[i].on & pwm[i] & s.conf[i].pwm_en)
              | (s.conf[i].on & ~s.conf[i].pwm_en);
         unique case (s.mode)
            DSMCC_NORMAL: begin
               // Direct input path needs no serial supply
               if (rst_lvl) begin // RULE6
                  next_s.hson[i] = s.ready & full;
               end else begin
                  next_s.hson[i] = s.ready & in_lvl[i]; // RULE17
               end
            end
            DSMCC_FAILSAFE: begin
               next_s.hson[i] = in_lvl[i]; // RULE17
            end
            DSMCC_FAULT: begin
               next_s.hson[i] = 1'b0; // RULE20
            end
            DSMCC_SLEEP: begin
               next_s.hson[i] = 1'b0;
            end
         endcase
      end

      next_s.slew = {s.conf[1].slew, s.conf[0].slew}; // RULE12
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.mode <= DSMCC_SLEEP;
         s.fs_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign hson = s.hson;
   assign normal_mode_flag = s.nm;
   assign fail_safe_n = s.fs_n;
   assign slew_code = s.slew;

endmodule

// ---- testbench/dsmcc_checker.sv ----
// Port assertions of the switch mode and channel control block
`timescale 1ns/1ps
module dsmcc_checker
   import dsmcc_pkg::*;
#(
   parameter int unsigned T_IN_CYC = 50
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic wake_reset_input,
   input wire logic [1:0] direct_in,
   input wire logic ext_clock,
   input wire logic [1:0] fault_in,
   input wire logic vdd_fail,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic [1:0] hson,
   input wire logic normal_mode_flag,
   input wire logic fail_safe_n,
   input wire logic [3:0] slew_code
);
   // ****************
   // Idle time of all wake sources
   // ****************
   int unsigned idle_cnt;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idle_cnt <= 0;
      end else if (wake_reset_input || direct_in != 2'h0) begin
         idle_cnt <= 0;
      end else if (idle_cnt < T_IN_CYC + 8) begin
         idle_cnt <= idle_cnt + 1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_fault_forces_off: assert property (
      (|fault_in) [*6] |-> hson == 2'h0 && !normal_mode_flag)
      else $error("channel or normal flag active during fault");
   a_wake_enters_normal: assert property (
      $rose(wake_reset_input) ##0
      (wake_reset_input && !vdd_fail && fault_in == 2'h0) [*6]
      |-> normal_mode_flag)
      else $error("wake rise did not reach normal mode");
   a_normal_not_fs: assert property (
      normal_mode_flag |-> fail_safe_n)
      else $error("normal flag together with fail-safe");
   a_sleep_after_idle: assert property (
      idle_cnt == T_IN_CYC + 8 |-> !normal_mode_flag && hson == 2'h0)
      else $error("no sleep after idle inputs");
   a_rdata_after_rd: assert property (
      !$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside answer cycle");
   a_fs_direct_only: assert property (
      (!fail_safe_n && fault_in == 2'h0 && $stable(direct_in)) [*6]
      |-> hson == direct_in)
      else $error("fail-safe channel not following direct input");
   a_idle_outputs_off: assert property (
      (!normal_mode_flag && fail_safe_n) [*2] |-> hson == 2'h0)
      else $error("channel on in sleep or fault");
   a_slew_by_write: assert property (
      $changed(slew_code) && wake_reset_input && $past(wake_reset_input, 4)
      && fail_safe_n && $past(fail_safe_n) |-> $past(wr) || $past(wr, 2))
      else $error("slew code changed without a write");
   c_normal: cover property ($rose(normal_mode_flag));
   c_failsafe: cover property ($fell(fail_safe_n));
   c_fault: cover property ((|fault_in) && (|hson));
endmodule

bind dsmcc_top dsmcc_checker #(.T_IN_CYC(T_IN_CYC)) u_chk (
   .clk(clk), .rstn(rstn), .wake_reset_input(wake_reset_input),
   .direct_in(direct_in), .ext_clock(ext_clock), .fault_in(fault_in),
   .vdd_fail(vdd_fail), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .hson(hson), .normal_mode_flag(normal_mode_flag),
   .fail_safe_n(fail_safe_n), .slew_code(slew_code));

// ---- testbench/dsmcc_mcu.sv ----
// Controller model driving wake, direct inputs and the register port
`timescale 1ns/1ps
module dsmcc_mcu (
   input wire logic clk,
   input wire logic [15:0] rdata,
   output logic wake_reset_input,
   output logic [1:0] direct_in,
   output logic [3:0] addr,
   output logic [15:0] wdata,
   output logic wr,
   output logic rd
);
   // ****************
   // Pin and bus tasks
   // ****************
   logic wd_bit = 1'b0;
   initial begin
      wake_reset_input = 1'b0;
      direct_in = 2'h0;
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end
   // Only called after reset release, so supplies are valid
   task automatic pins(input logic w, input logic [1:0] i);
      @(posedge clk);
      wake_reset_input <= w;
      direct_in <= i;
   endtask
   // Each write flips the keep-alive bit
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= {wd_bit, v[14:0]};
      wd_bit <= ~wd_bit;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~wdata;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      @(negedge clk);
      v = rdata;
   endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench of the switch mode and channel control block
`timescale 1ns/1ps
module testbench;
   import dsmcc_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ext_clock = 1'b0;
   logic [1:0] fault_in = 2'h0;
   logic vdd_fail = 1'b0;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, d;
   logic wr, rd, wake_reset_input, normal_mode_flag, fail_safe_n;
   logic [1:0] direct_in, hson, in;
   logic [3:0] slew_code;
   logic [11:0] c0, c1;
   int err_total = 0;
   int n_checks = 0;
`define CHK(nm, exp, got) \
   begin n_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
   always #4 clk = ~clk;
   dsmcc_top #(.T_READY_CYC(20), .T_IN_CYC(50), .T_WDTO_CYC(80)) dut (
      .clk(clk), .rstn(rstn), .wake_reset_input(wake_reset_input),
      .direct_in(direct_in), .ext_clock(ext_clock), .fault_in(fault_in),
      .vdd_fail(vdd_fail), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .hson(hson), .normal_mode_flag(normal_mode_flag),
      .fail_safe_n(fail_safe_n), .slew_code(slew_code));
   dsmcc_mcu mcu (.clk(clk), .rdata(rdata),
      .wake_reset_input(wake_reset_input), .direct_in(direct_in),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   // ****************
   // Helpers
   // ****************
   function automatic logic [1:0] exp_hson(logic [1:0] i, logic [11:0] a, b);
      exp_hson[0] = (i[0] & ~a[3]) | (a[0] & ~a[1]);
      exp_hson[1] = (i[1] & ~b[3]) | (b[0] & ~b[1]);
   endfunction
   // Ends off the edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_of_test();
   end
   // ****************
   // Scenarios
   // ****************
   initial begin
      void'($urandom(98529));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      tick(2);
      `CHK("idle nm", 1'b0, normal_mode_flag)
      `CHK("idle hson", 2'h0, hson)
      mcu.pins(1'b1, 2'h0);
      tick(30);
      `CHK("wake nm", 1'b1, normal_mode_flag)
      mcu.rd_reg(4'h1, d);
      `CHK("status", 16'h0050, d)
      mcu.rd_reg(4'hF, d);
      `CHK("unmapped", 16'h0000, d)
      for (int k = 0; k < 24; k++) begin
         c0 = 12'($urandom);
         c1 = 12'($urandom);
         in = 2'($urandom);
         if (k == 0) begin
            c0 = 12'h003;
            c1 = 12'h008;
            in = 2'h3;
         end
         mcu.wr_reg(4'h4, {4'h0, c0});
         mcu.wr_reg(4'h5, {4'h0, c1});
         mcu.pins(1'b1, in);
         tick(8);
         `CHK("hson", exp_hson(in, c0, c1), hson)
         `CHK("slew", {c1[8:7], c0[8:7]}, slew_code)
      end
      // External period restart puts the step at zero
      mcu.wr_reg(4'h5, 16'h0000);
      mcu.wr_reg(4'h2, 16'h0080);
      mcu.wr_reg(4'h4, 16'h0003);
      mcu.pins(1'b1, 2'h0);
      @(posedge clk);
      ext_clock <= 1'b1;
      repeat (10) @(posedge clk);
      ext_clock <= 1'b0;
      @(negedge clk);
      `CHK("duty on", 2'h1, hson)
      mcu.wr_reg(4'h2, 16'h0000);
      tick(8);
      `CHK("duty off", 2'h0, hson)
      // Internal clock: duty 1 is on in step 0 only, one step is 489 cycles
      // Even count of writes keeps the keep-alive bit phase for later
      mcu.wr_reg(4'h2, 16'h0001);
      mcu.wr_reg(4'h4, 16'h0007);
      tick(8);
      `CHK("int clk on", 2'h1, hson)
      repeat (10) begin
         mcu.wr_reg(4'h0, 16'h0000);
         tick(45);
      end
      `CHK("int clk off", 2'h0, hson)
      mcu.wr_reg(4'h4, 16'h0001);
      @(posedge clk);
      fault_in <= 2'h1;
      tick(8);
      `CHK("fault hson", 2'h0, hson)
      `CHK("fault nm", 1'b0, normal_mode_flag)
      @(posedge clk);
      fault_in <= 2'h0;
      tick(8);
      `CHK("fault gone", 2'h1, hson)
      // Fault bit outlives the fault and clears on its read
      mcu.rd_reg(4'h6, d);
      `CHK("fault bit", 16'h0001, d)
      mcu.rd_reg(4'h6, d);
      `CHK("fault cleared", 16'h0000, d)
      mcu.pins(1'b1, 2'h2);
      tick(100);
      `CHK("wd timeout", 1'b0, fail_safe_n)
      `CHK("fs nm", 1'b0, normal_mode_flag)
      `CHK("fs hson", 2'h2, hson)
      mcu.wr_reg(4'h0, 16'h0000);
      mcu.wr_reg(4'h0, 16'h0000);
      tick(6);
      `CHK("fs exit", 1'b1, fail_safe_n)
      mcu.wr_reg(4'h0, 16'h0010);
      tick(100);
      `CHK("wd disabled", 1'b1, fail_safe_n)
      `CHK("watchdog_disable nm", 1'b1, normal_mode_flag)
      mcu.pins(1'b0, 2'h0);
      tick(40);
      `CHK("input held", 1'b1, normal_mode_flag)
      tick(30);
      `CHK("sleep", 1'b0, normal_mode_flag)
      mcu.pins(1'b0, 2'h1);
      tick(10);
      `CHK("not ready", 2'h0, hson)
      tick(20);
      `CHK("direct wake", 1'b1, normal_mode_flag)
      `CHK("direct hson", 2'h1, hson)
      mcu.pins(1'b0, 2'h0);
      tick(70);
      `CHK("input timeout", 1'b0, normal_mode_flag)
      mcu.pins(1'b1, 2'h0);
      tick(8);
      `CHK("regs cleared", 4'h0, slew_code)
      end_of_test();
   end
endmodule
